// *** inc/litdec_consts.svh ***
// constants of the literal and table instruction decoder
`ifndef LITDEC_CONSTS_SVH
`define LITDEC_CONSTS_SVH

// widths
`define LD_DATA_W 8
`define LD_FLAG_W 5
`define LD_BANK_W 4
`define LD_PTRF_W 12
`define LD_TPTR_W 21
`define LD_APB_AW 8
`define LD_HOLD_AW 3

// instruction word field boundaries
`define LD_IW_TOP 15
`define LD_OPHI_LSB 8
`define LD_TBL_LSB 2
`define LD_BANKOP_LSB 4
`define LD_PTROP_LSB 6

// reset value and status bit position
`define LD_HOLD_RST 8'hff
`define LD_BUSY_BIT 0

// opcode upper bytes of the literal group, then bank, pointer and table opcode prefixes
`define LD_OP_ADD 8'h0f
`define LD_OP_AND 8'h0b
`define LD_OP_OR 8'h09
`define LD_OP_XOR 8'h0a
`define LD_OP_RSUB 8'h08
`define LD_OP_LOAD 8'h0e
`define LD_OP_MUL 8'h0d
`define LD_OP_RET 8'h0c
`define LD_OP_BANK 12'h010
`define LD_OP_PTR1 10'h3b8
`define LD_OP_PTR2 8'hf0
`define LD_OP_PROGRAM_MEMORY_READ 14'h0002
`define LD_OP_PROGRAM_MEMORY_WRITE 14'h0003

// table pointer variants
`define LD_TV_PLAIN 2'h0
`define LD_TV_POSTINC 2'h1
`define LD_TV_POSTDEC 2'h2
`define LD_TV_PREINC 2'h3

// status flag positions
`define LD_FL_C 0
`define LD_FL_DC 1
`define LD_FL_Z 2
`define LD_FL_OV 3
`define LD_FL_N 4

// register offsets
`define LD_REG_WORK 8'h00
`define LD_REG_STAT 8'h04
`define LD_REG_BANK 8'h08
`define LD_REG_PROD 8'h0c
`define LD_REG_PTR0 8'h10
`define LD_REG_PTR1 8'h14
`define LD_REG_PTR2 8'h18
`define LD_REG_TLAT 8'h1c
`define LD_REG_TPTR 8'h20
`define LD_REG_HOLD 8'h24
`define LD_REG_BUSY 8'h28

// file addresses seen by the modify checks, and the pointer selector that names no pointer
`define LD_FA_TIMER 8'hd6
`define LD_FA_PORTA 8'h80
`define LD_FA_PORTB 8'h81
`define LD_PTR_NONE 2'h3

`endif

// *** inc/litdec_pkg.sv ***
// types of the literal and table instruction decoder
`include "litdec_consts.svh"

package litdec_pkg;

  typedef enum logic [2:0] {ST_FETCH, ST_NOP, ST_PTR2, ST_TBLRD2, ST_TBLWT2} litdec_state_e;

  typedef enum logic [2:0] {ALU_ADD, ALU_AND, ALU_OR, ALU_XOR, ALU_RSUB, ALU_PASS} litdec_aluop_e;

  typedef struct packed {
    litdec_state_e state;
    logic [`LD_DATA_W-1:0] work;
    logic [`LD_FLAG_W-1:0] flags;
    logic [`LD_BANK_W-1:0] bank;
    logic [2*`LD_DATA_W-1:0] prod;
    logic [2:0][`LD_PTRF_W-1:0] fptr;
    logic [1:0] ptrSel;
    logic [3:0] ptrHi;
    logic [`LD_DATA_W-1:0] tlat;
    logic [`LD_TPTR_W-1:0] tptr;
    logic [1:0] tblVar;
    logic retPulse;
    logic preClr;
    logic [31:0] prdata;
  } litdec_state_s;

endpackage

// *** logic/litdec_alu.sv ***
// literal arithmetic and logic unit with flag outputs
`timescale 1ns/1ps
`default_nettype none
`include "litdec_consts.svh"

module litdec_alu
(
  input wire litdec_pkg::litdec_aluop_e aluOp,
  input wire logic [`LD_DATA_W-1:0] work,
  input wire logic [`LD_DATA_W-1:0] lit,
  output logic [`LD_DATA_W-1:0] result,
  output logic [`LD_FLAG_W-1:0] flags,
  output logic [2*`LD_DATA_W-1:0] product
);

  logic [`LD_DATA_W:0] sum;
  logic [`LD_DATA_W:0] diff;
  logic [4:0] nibSum;
  localparam int MSB = `LD_DATA_W - 1;

  assign sum = {1'b0, work} + {1'b0, lit};
  assign diff = {1'b0, lit} - {1'b0, work};
  assign nibSum = {1'b0, work[3:0]} + {1'b0, lit[3:0]};
  assign product = {{`LD_DATA_W{1'b0}}, lit} * {{`LD_DATA_W{1'b0}}, work};

  always_comb
  begin
    flags = '0;
    unique case (aluOp)
      litdec_pkg::ALU_ADD:
      begin
        result = sum[`LD_DATA_W-1:0];
        flags[`LD_FL_C] = sum[`LD_DATA_W];
        flags[`LD_FL_DC] = nibSum[4];
        flags[`LD_FL_OV] = (work[MSB] == lit[MSB]) && (result[MSB] != work[MSB]);
      end
      litdec_pkg::ALU_RSUB:
      begin
        // carry and digit carry read as no-borrow
        result = diff[`LD_DATA_W-1:0];
        flags[`LD_FL_C] = ~diff[`LD_DATA_W];
        flags[`LD_FL_DC] = (lit[3:0] >= work[3:0]);
        flags[`LD_FL_OV] = (work[MSB] != lit[MSB]) && (result[MSB] != lit[MSB]);
      end
      litdec_pkg::ALU_AND: result = work & lit;
      litdec_pkg::ALU_OR: result = work | lit;
      litdec_pkg::ALU_XOR: result = work ^ lit;
      default: result = lit;
    endcase
    flags[`LD_FL_Z] = (result == '0);
    flags[`LD_FL_N] = result[MSB];
  end

endmodule // litdec_alu
`default_nettype wire

// *** logic/litdec_hold_mem.sv ***
// program-memory write holding registers, registered read port
`timescale 1ns/1ps
`default_nettype none
`include "litdec_consts.svh"

module litdec_hold_mem
#(
  parameter int DEPTH = 8
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wrEn,
  input wire logic [`LD_HOLD_AW-1:0] wrAddr,
  input wire logic [`LD_DATA_W-1:0] wrData,
  input wire logic [`LD_HOLD_AW-1:0] rdAddr,
  output logic [`LD_DATA_W-1:0] rdData
);

  logic [`LD_DATA_W-1:0] mem_ff [DEPTH];

  // erased flash reads as all ones, so the holding bytes start there too
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
        mem_ff[i] <= `LD_HOLD_RST;
      else if (wrEn && (wrAddr == `LD_HOLD_AW'(i)))
        mem_ff[i] <= wrData;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdData <= `LD_HOLD_RST;
    else
      rdData <= mem_ff[rdAddr];
  end

endmodule // litdec_hold_mem
`default_nettype wire

// *** logic/litdec_core.sv ***
// literal and table instruction decoder with APB register access
// ============================================================
// Overview of operation
// - upper byte 0F adds literal to work register, sets C DC Z OV N.
// - upper byte 0B ANDs literal into work register, sets Z and N.
// - upper byte 09 ORs literal into work register, sets Z and N.
// - upper byte 0A XORs literal into work register, sets Z and N.
// - upper byte 08 stores literal minus work register, sets C DC Z OV N.
// - upper byte 0E loads literal into work register, flags untouched.
// - upper byte 0D multiplies literal by work register, flags untouched.
// - 0010k loads four-bit literal into bank selector, one cycle.
// - upper byte 0C loads literal, returns, two cycles, no flags.
// - two-word pointer load puts a 12-bit literal in chosen pointer.
// - 000008..0B table reads, four pointer variants, two cycles.
// - 00000C..0F table writes, four pointer variants, two cycles.
// - table write copies latch byte to holding register, adjusts pointer.
// - program-counter changes take two cycles, second one a no-op.
// - lone second word of two-word instruction runs as a no-op.
// - port read-modify-write takes its source from pin levels.
// - modifying timer-zero count clears its assigned prescaler.
`timescale 1ns/1ps
`default_nettype none
`include "litdec_consts.svh"

module litdec_core
#(
  parameter int HOLD_DEPTH = 8
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [`LD_APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  output logic instrReady,
  output logic retReq,
  output logic [`LD_TPTR_W-1:0] pmRdAddr,
  input wire logic [`LD_DATA_W-1:0] pmRdData,
  input wire logic fileOpValid,
  input wire logic fileOpModify,
  input wire logic fileOpDestFile,
  input wire logic [`LD_APB_AW-1:0] fileOpAddr,
  input wire logic prescalerAssigned,
  output logic usePinLevels,
  output logic prescalerClr
);

  // ============================================================
  // state and wires

  litdec_pkg::litdec_state_s st_ff;
  litdec_pkg::litdec_state_s nxt_st;
  litdec_pkg::litdec_aluop_e aluOp;
  logic [`LD_DATA_W-1:0] aluRes;
  logic [`LD_FLAG_W-1:0] aluFlags;
  logic [2*`LD_DATA_W-1:0] aluProd;
  logic [`LD_DATA_W-1:0] holdRd;
  logic holdWe;
  logic [`LD_DATA_W-1:0] lit;
  logic [7:0] opHi;
  logic take;
  logic apbSetup;
  logic apbWrite;
  logic addrHit;
  logic [31:0] rdVal;
  logic isPort;
  logic [1:0] tblMode;
  logic isTblRd;
  logic isTblWt;
  logic isBank;
  logic isPtrLoad;
  logic busy;
  logic [`LD_TPTR_W-1:0] tptrUp;
  logic [`LD_TPTR_W-1:0] tptrDown;

  // ============================================================
  // instruction field decode

  assign lit = instrWord[`LD_OPHI_LSB-1:0];
  assign opHi = instrWord[`LD_IW_TOP:`LD_OPHI_LSB];
  assign tblMode = instrWord[`LD_TBL_LSB-1:0];
  assign isTblRd = (instrWord[`LD_IW_TOP:`LD_TBL_LSB] == `LD_OP_PROGRAM_MEMORY_READ);
  assign isTblWt = (instrWord[`LD_IW_TOP:`LD_TBL_LSB] == `LD_OP_PROGRAM_MEMORY_WRITE);
  assign isBank = (instrWord[`LD_IW_TOP:`LD_BANKOP_LSB] == `LD_OP_BANK);
  assign isPtrLoad = (instrWord[`LD_IW_TOP:`LD_PTROP_LSB] == `LD_OP_PTR1);

  // one adder pair serves every pointer variant of both table groups
  assign tptrUp = st_ff.tptr + 1'b1;
  assign tptrDown = st_ff.tptr - 1'b1;

  // ============================================================
  // alu opcode decode

  function automatic litdec_pkg::litdec_aluop_e decodeAlu(input logic [7:0] hi);
    litdec_pkg::litdec_aluop_e op;
    op = litdec_pkg::ALU_PASS;
    unique case (hi)
      `LD_OP_ADD: op = litdec_pkg::ALU_ADD;
      `LD_OP_AND: op = litdec_pkg::ALU_AND;
      `LD_OP_OR: op = litdec_pkg::ALU_OR;
      `LD_OP_XOR: op = litdec_pkg::ALU_XOR;
      `LD_OP_RSUB: op = litdec_pkg::ALU_RSUB;
      default: op = litdec_pkg::ALU_PASS;
    endcase
    return op;
  endfunction

  assign aluOp = decodeAlu(opHi);

  litdec_alu litdec_alu_inst
  (
    .aluOp(aluOp),
    .work(st_ff.work),
    .lit(lit),
    .result(aluRes),
    .flags(aluFlags),
    .product(aluProd)
  );

  // holding read port lags a pointer change by one cycle
  litdec_hold_mem #(.DEPTH(HOLD_DEPTH)) litdec_hold_mem_inst
  (
    .mclk(mclk),
    .resetn(resetn),
    .wrEn(holdWe),
    .wrAddr(st_ff.tptr[`LD_HOLD_AW-1:0]),
    .wrData(st_ff.tlat),
    .rdAddr(st_ff.tptr[`LD_HOLD_AW-1:0]),
    .rdData(holdRd)
  );

  // ============================================================
  // apb decode

  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  // every register answers from flops or decode, so no wait state is ever needed
  assign pready = 1'b1;
  // busy covers the flushed slot after a return and a pending second pointer word
  assign busy = (st_ff.state != litdec_pkg::ST_FETCH);

  always_comb
  begin
    addrHit = 1'b1;
    rdVal = '0;
    unique case (paddr)
      `LD_REG_WORK: rdVal[`LD_DATA_W-1:0] = st_ff.work;
      `LD_REG_STAT: rdVal[`LD_FLAG_W-1:0] = st_ff.flags;
      `LD_REG_BANK: rdVal[`LD_BANK_W-1:0] = st_ff.bank;
      `LD_REG_PROD: rdVal[2*`LD_DATA_W-1:0] = st_ff.prod;
      `LD_REG_PTR0: rdVal[`LD_PTRF_W-1:0] = st_ff.fptr[0];
      `LD_REG_PTR1: rdVal[`LD_PTRF_W-1:0] = st_ff.fptr[1];
      `LD_REG_PTR2: rdVal[`LD_PTRF_W-1:0] = st_ff.fptr[2];
      `LD_REG_TLAT: rdVal[`LD_DATA_W-1:0] = st_ff.tlat;
      `LD_REG_TPTR: rdVal[`LD_TPTR_W-1:0] = st_ff.tptr;
      `LD_REG_HOLD: rdVal[`LD_DATA_W-1:0] = holdRd;
      `LD_REG_BUSY: rdVal[`LD_BUSY_BIT] = busy;
      default: addrHit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addrHit;

  // ============================================================
  // file-register modify side effects

  assign isPort = (fileOpAddr == `LD_FA_PORTA) || (fileOpAddr == `LD_FA_PORTB);
  assign usePinLevels = fileOpValid & fileOpModify & isPort;

  // ============================================================
  // sequencer

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.retPulse = 1'b0;
    nxt_st.preClr = 1'b0;
    holdWe = 1'b0;
    instrReady = 1'b0;
    take = 1'b0;

    // timer-zero modify with file destination drops the prescaler count
    if (fileOpValid && fileOpModify && fileOpDestFile && prescalerAssigned
        && (fileOpAddr == `LD_FA_TIMER))
      nxt_st.preClr = 1'b1;

    unique case (st_ff.state)
      litdec_pkg::ST_FETCH:
      begin
        instrReady = 1'b1;
        take = instrValid;
      end
      litdec_pkg::ST_NOP:
      begin
        // word fetched behind a return is flushed unexecuted
        instrReady = 1'b1;
        if (instrValid)
          nxt_st.state = litdec_pkg::ST_FETCH;
      end
      litdec_pkg::ST_PTR2:
      begin
        instrReady = 1'b1;
        if (instrValid)
        begin
          nxt_st.state = litdec_pkg::ST_FETCH;
          // selector 3 names no pointer, so that pair retires with no load
          if ((opHi == `LD_OP_PTR2) && (st_ff.ptrSel != `LD_PTR_NONE))
            nxt_st.fptr[st_ff.ptrSel] = {st_ff.ptrHi, lit};
        end
      end
      litdec_pkg::ST_TBLRD2:
      begin
        nxt_st.tlat = pmRdData;
        nxt_st.state = litdec_pkg::ST_FETCH;
        if (st_ff.tblVar == `LD_TV_POSTINC)
          nxt_st.tptr = tptrUp;
        else if (st_ff.tblVar == `LD_TV_POSTDEC)
          nxt_st.tptr = tptrDown;
      end
      litdec_pkg::ST_TBLWT2:
      begin
        // latch byte lands at the end of the second cycle
        holdWe = 1'b1;
        nxt_st.state = litdec_pkg::ST_FETCH;
        if (st_ff.tblVar == `LD_TV_POSTINC)
          nxt_st.tptr = tptrUp;
        else if (st_ff.tblVar == `LD_TV_POSTDEC)
          nxt_st.tptr = tptrDown;
      end
    endcase

    if (take)
    begin
      if (isTblRd)
      begin
        nxt_st.tblVar = tblMode;
        nxt_st.state = litdec_pkg::ST_TBLRD2;
        if (tblMode == `LD_TV_PREINC)
          nxt_st.tptr = tptrUp;
      end
      else if (isTblWt)
      begin
        nxt_st.tblVar = tblMode;
        nxt_st.state = litdec_pkg::ST_TBLWT2;
        if (tblMode == `LD_TV_PREINC)
          nxt_st.tptr = tptrUp;
      end
      else if (isBank)
        nxt_st.bank = instrWord[`LD_BANKOP_LSB-1:0];
      else if (isPtrLoad)
      begin
        nxt_st.ptrSel = instrWord[`LD_PTROP_LSB-1:`LD_BANKOP_LSB];
        nxt_st.ptrHi = instrWord[`LD_BANKOP_LSB-1:0];
        nxt_st.state = litdec_pkg::ST_PTR2;
      end
      else
      begin
        unique case (opHi)
          `LD_OP_ADD, `LD_OP_RSUB:
          begin
            nxt_st.work = aluRes;
            nxt_st.flags = aluFlags;
          end
          `LD_OP_AND, `LD_OP_OR, `LD_OP_XOR:
          begin
            nxt_st.work = aluRes;
            nxt_st.flags[`LD_FL_Z] = aluFlags[`LD_FL_Z];
            nxt_st.flags[`LD_FL_N] = aluFlags[`LD_FL_N];
          end
          `LD_OP_LOAD: nxt_st.work = lit;
          `LD_OP_MUL: nxt_st.prod = aluProd;
          `LD_OP_RET:
          begin
            nxt_st.work = lit;
            nxt_st.retPulse = 1'b1;
            nxt_st.state = litdec_pkg::ST_NOP;
          end
          // a stray second word, or any other group, retires as a no-op
          default: nxt_st.state = litdec_pkg::ST_FETCH;
        endcase
      end
    end

    // software writes win over a same-cycle instruction update
    if (apbWrite)
    begin
      unique case (paddr)
        `LD_REG_WORK: nxt_st.work = pwdata[`LD_DATA_W-1:0];
        `LD_REG_STAT: nxt_st.flags = pwdata[`LD_FLAG_W-1:0];
        `LD_REG_BANK: nxt_st.bank = pwdata[`LD_BANK_W-1:0];
        `LD_REG_PTR0: nxt_st.fptr[0] = pwdata[`LD_PTRF_W-1:0];
        `LD_REG_PTR1: nxt_st.fptr[1] = pwdata[`LD_PTRF_W-1:0];
        `LD_REG_PTR2: nxt_st.fptr[2] = pwdata[`LD_PTRF_W-1:0];
        `LD_REG_TLAT: nxt_st.tlat = pwdata[`LD_DATA_W-1:0];
        `LD_REG_TPTR: nxt_st.tptr = pwdata[`LD_TPTR_W-1:0];
        default: nxt_st.work = nxt_st.work;
      endcase
    end

    // read data is caught in the setup cycle so the access needs no wait
    if (apbSetup)
      nxt_st.prdata = rdVal;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff.state <= litdec_pkg::ST_FETCH;
      st_ff.work <= '0;
      st_ff.flags <= '0;
      st_ff.bank <= '0;
      st_ff.prod <= '0;
      st_ff.fptr <= '0;
      st_ff.ptrSel <= '0;
      st_ff.ptrHi <= '0;
      st_ff.tlat <= '0;
      st_ff.tptr <= '0;
      st_ff.tblVar <= '0;
      st_ff.retPulse <= 1'b0;
      st_ff.preClr <= 1'b0;
      st_ff.prdata <= '0;
    end
    else
      st_ff <= nxt_st;
  end

  // ============================================================
  // outputs

  assign prdata = st_ff.prdata;
  assign retReq = st_ff.retPulse;
  assign prescalerClr = st_ff.preClr;
  assign pmRdAddr = st_ff.tptr;

endmodule // litdec_core
`default_nettype wire

// *** verif/litdec_monitor.sv ***
// port assertions for the literal and table decoder
`timescale 1ns/1ps
`default_nettype none
`include "litdec_consts.svh"

module litdec_monitor
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [`LD_APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic instrReady,
  input wire logic retReq,
  input wire logic [`LD_TPTR_W-1:0] pmRdAddr,
  input wire logic fileOpValid,
  input wire logic fileOpModify,
  input wire logic fileOpDestFile,
  input wire logic [`LD_APB_AW-1:0] fileOpAddr,
  input wire logic prescalerAssigned,
  input wire logic usePinLevels,
  input wire logic prescalerClr
);
  // ==========================================================
  // helpers
  // a word taken while retReq is high is discarded, so it is no take
  logic take;
  logic tbl;
  logic tmrMod;
  assign take = instrValid && instrReady && !retReq;
  assign tbl = take && instrWord[15:3] == 13'h0001;
  assign tmrMod = fileOpValid && fileOpModify && fileOpDestFile && prescalerAssigned
    && fileOpAddr == `LD_FA_TIMER;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // ==========================================================
  // assertions
  chk_ret_pulse: assert property (
    take && instrWord[15:8] == `LD_OP_RET |=> retReq ##1 !retReq) else $error("no ret pulse");
  chk_ret_cause: assert property (
    $rose(retReq) |-> $past(take && instrWord[15:8] == `LD_OP_RET)) else $error("stray ret");
  chk_tbl_stall: assert property (
    tbl |=> !instrReady ##1 instrReady) else $error("table op not two cycles");
  chk_ptr_preinc: assert property (
    tbl && instrWord[1:0] == `LD_TV_PREINC |=> pmRdAddr == $past(pmRdAddr) + 1'h1)
    else $error("pre-increment wrong");
  chk_ptr_postinc: assert property (
    tbl && instrWord[1:0] == `LD_TV_POSTINC |=> ##1 pmRdAddr == $past(pmRdAddr, 2) + 1'h1)
    else $error("post-increment wrong");
  chk_ptr_postdec: assert property (
    tbl && instrWord[1:0] == `LD_TV_POSTDEC |=> ##1 pmRdAddr == $past(pmRdAddr, 2) - 1'h1)
    else $error("post-decrement wrong");
  chk_ptr_plain: assert property (
    tbl && instrWord[1:0] == `LD_TV_PLAIN |=> ##1 pmRdAddr == $past(pmRdAddr, 2))
    else $error("plain table op moved pointer");
  chk_pin_levels: assert property (
    usePinLevels == (fileOpValid && fileOpModify
    && (fileOpAddr == `LD_FA_PORTA || fileOpAddr == `LD_FA_PORTB))) else $error("pin select");
  chk_presc_clr: assert property (
    tmrMod |=> prescalerClr) else $error("prescaler not cleared");
  chk_presc_cause: assert property (
    prescalerClr |-> $past(tmrMod)) else $error("stray prescaler clear");
  chk_apb_unmapped: assert property (
    psel && penable && paddr > `LD_REG_BUSY |-> pready && pslverr) else $error("no slave error");
endmodule // litdec_monitor

bind litdec_core litdec_monitor litdec_monitor_inst (.mclk, .resetn, .paddr, .psel, .penable,
  .pready, .pslverr, .instrValid, .instrWord, .instrReady, .retReq, .pmRdAddr, .fileOpValid,
  .fileOpModify, .fileOpDestFile, .fileOpAddr, .prescalerAssigned, .usePinLevels, .prescalerClr);
`default_nettype wire

// *** verif/litdec_pm_model.sv ***
// program memory byte model seen by table reads
`timescale 1ns/1ps
`default_nettype none

module litdec_pm_model
(
  input wire logic [20:0] pmRdAddr,
  output logic [7:0] pmRdData
);
  // address-derived bytes so a wrong pointer shows as wrong data
  assign pmRdData = pmRdAddr[7:0] ^ 8'ha5;
endmodule // litdec_pm_model
`default_nettype wire

// *** verif/litdec_core_tb.sv ***
// self-checking bench for the literal and table decoder
`timescale 1ns/1ps
`default_nettype none
`include "litdec_consts.svh"

module litdec_core_tb;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic instrValid, instrReady, retReq, fileOpValid, fileOpModify, fileOpDestFile;
  logic prescalerAssigned, usePinLevels, prescalerClr;
  logic [7:0] paddr, pmRdData, fileOpAddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] instrWord;
  logic [20:0] pmRdAddr, base, used;
  int nErrors, checked;
  localparam logic [15:0] OPS [8] = '{16'h0e3c, 16'h0fc4, 16'h0e7f, 16'h0980,
    16'h0b00, 16'h0a80, 16'h0801, 16'h0d03};
  localparam logic [7:0] EW [8] = '{8'h3c, 8'h00, 8'h7f, 8'hff, 8'h00, 8'h80, 8'h81, 8'h81};
  localparam logic [7:0] ES [8] = '{8'h00, 8'h07, 8'h07, 8'h13, 8'h07, 8'h13, 8'h1a, 8'h1a};
  localparam logic [31:0] PD [4] = '{32'h0000_0000, 32'h0000_0001, 32'hffff_ffff, 32'h0000_0001};

  litdec_core litdec_core_inst (.mclk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .instrValid, .instrWord, .instrReady, .retReq, .pmRdAddr,
    .pmRdData, .fileOpValid, .fileOpModify, .fileOpDestFile, .fileOpAddr, .prescalerAssigned,
    .usePinLevels, .prescalerClr);
  litdec_pm_model litdec_pm_model_inst (.pmRdAddr, .pmRdData);

  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // ==========================================================
  // tasks
  task automatic tally_and_finish();
    if (nErrors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // release plus one idle edge, so back-to-back calls never drive psel twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    for (int i = 0; i < 16 && !done; i++)
    begin
      @(posedge mclk);
      done = pready;
      if (done)
      begin
        rdat = prdata;
        rerr = pslverr;
      end
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
    if (!done)
    begin
      nErrors++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  // valid stays up so consecutive calls issue back-to-back words
  task automatic exec(input logic [15:0] w);
    bit done;
    done = 0;
    instrValid <= 1'h1;
    instrWord <= w;
    for (int i = 0; i < 16 && !done; i++)
    begin
      @(posedge mclk);
      done = instrReady;
    end
    if (!done)
    begin
      nErrors++;
      tally_and_finish();
    end
  endtask

  task automatic idle();
    instrValid <= 1'h0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic fop(input logic [7:0] a, input logic [2:0] mda, input logic pin, input logic clr);
    fileOpValid <= 1'h1;
    {fileOpModify, fileOpDestFile, prescalerAssigned} <= mda;
    fileOpAddr <= a;
    @(negedge mclk);
    chk(32'(usePinLevels), 32'(pin));
    @(posedge mclk);
    fileOpValid <= 1'h0;
    @(negedge mclk);
    chk(32'(prescalerClr), 32'(clr));
    @(posedge mclk);
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    nErrors = 0;
    checked = 0;
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    instrValid = 1'h0;
    instrWord = 16'h0000;
    fileOpValid = 1'h0;
    fileOpModify = 1'h0;
    fileOpDestFile = 1'h0;
    fileOpAddr = 8'h00;
    prescalerAssigned = 1'h0;
    repeat (16) @(posedge mclk);
    resetn <= 1'h1;
    @(posedge mclk);
    rd(`LD_REG_TPTR, 32'h0000_0000);
    rd(`LD_REG_HOLD, 32'h0000_00ff);
    rd(`LD_REG_BUSY, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      exec(OPS[i]);
      idle();
      rd(`LD_REG_WORK, 32'(EW[i]));
      rd(`LD_REG_STAT, 32'(ES[i]));
    end
    rd(`LD_REG_PROD, 32'h0000_0183);
    apb(1'h1, `LD_REG_PROD, 32'h0000_ffff);
    rd(`LD_REG_PROD, 32'h0000_0183);
    exec(16'h0105);
    exec(16'h0c42);
    exec(16'h0e99);
    exec(16'hee1a);
    exec(16'hf0bc);
    exec(16'hf012);
    exec(16'hee3f);
    exec(16'hf055);
    exec(16'hee2f);
    exec(16'h0e55);
    idle();
    rd(`LD_REG_BANK, 32'h0000_0005);
    rd(`LD_REG_WORK, 32'h0000_0042);
    rd(`LD_REG_STAT, 32'h0000_001a);
    rd(`LD_REG_PTR1, 32'h0000_0abc);
    rd(`LD_REG_PTR0, 32'h0000_0000);
    rd(`LD_REG_PTR2, 32'h0000_0000);
    exec(16'h0c11);
    idle();
    rd(`LD_REG_BUSY, 32'h0000_0001);
    exec(16'h0e22);
    idle();
    rd(`LD_REG_WORK, 32'h0000_0011);
    rd(`LD_REG_BUSY, 32'h0000_0000);
    for (int v = 0; v < 8; v++)
    begin
      base = 21'h01_389a;
      used = base + 21'((v % 4) == 3);
      apb(1'h1, `LD_REG_TPTR, 32'(base));
      apb(1'h1, `LD_REG_TLAT, 32'h0000_0030 + 32'(v));
      exec(16'h0008 + 16'(v));
      idle();
      rd(`LD_REG_TPTR, 32'(base) + PD[v % 4]);
      if (v < 4)
        rd(`LD_REG_TLAT, 32'(used[7:0] ^ 8'ha5));
      else
      begin
        apb(1'h1, `LD_REG_TPTR, 32'(used));
        rd(`LD_REG_HOLD, 32'h0000_0030 + 32'(v));
      end
    end
    fop(`LD_FA_PORTA, 3'h4, 1'h1, 1'h0);
    fop(`LD_FA_PORTB, 3'h7, 1'h1, 1'h0);
    fop(`LD_FA_PORTA, 3'h0, 1'h0, 1'h0);
    fop(`LD_FA_TIMER, 3'h7, 1'h0, 1'h1);
    fop(`LD_FA_TIMER, 3'h6, 1'h0, 1'h0);
    fop(`LD_FA_TIMER, 3'h5, 1'h0, 1'h0);
    apb(1'h0, 8'h40, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
    chk(rdat, 32'h0000_0000);
    tally_and_finish();
  end
endmodule // litdec_core_tb
`default_nettype wire
